// ### core/rwg_pkg.sv
package rwg_pkg;

  // system clock
  localparam int CLK_MHZ = 100;

  // reset hold times, microseconds
  localparam int PWRUP_DELAY_US = 20000;
  localparam int CHARGE_DELAY_US = 20000;
  localparam int PWRUP_CYC = PWRUP_DELAY_US * CLK_MHZ;
  localparam int CHARGE_CYC = CHARGE_DELAY_US * CLK_MHZ;
  localparam int DLY_W = 24;

  // watchdog: 2**19 strobe cycles at the nominal 390.4 kHz strobe is about 1.34 s
  localparam int WD_TIMEOUT_MS = 1300;
  localparam int WD_W = 20;
  localparam int WD_TAP = 19;

  // memory geometry
  localparam int RAM_AW = 8;
  localparam int RAM_DW = 4;
  localparam int RAM_DEPTH = 256;

  // register map, byte offsets within the slave window
  localparam int DEC_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] WDCNT_OFF = 12'h008;

  // control register fields
  localparam int CTRL_WD_EN_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam logic CTRL_WD_EN_RST = 1'b1;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_RUN, ST_WDREQ} rwg_state_t;

  typedef struct packed {
    logic [1:0] state;
    logic cal_sw;
    logic supply_ok;
    logic ram_enable_hi;
    logic reset_req;
    logic ctrl_reset_n;
  } rwg_status_t;

  typedef struct packed {
    logic enable_hi;
    logic select_lo;
    logic output_disable;
    logic rw_n;
  } rwg_ram_ctl_t;

endpackage : rwg_pkg

// ### core/rwg_top.sv
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - watchdog counter advances once per address latch strobe cycle.
// - every keyboard scan line edge clears the watchdog counter to zero.
// - without clears the counter runs about 1.3 s, then raises reset request.
// - reset request pulls controller reset line low.
// - while reset is held counting stops and reset request drops.
// - after request drops, reset stays low for a charge delay, then releases.
// - at power-up, reset held low for a delay after supply valid.
// - supply below valid level drives reset low immediately.
// - single-step follows reset; controller drives program store enable high first.
// - calibration RAM enable is low whenever reset is low.
// - RAM responds only while its enable is high: powered and out of reset.
// - RAM drives nibble only when read strobe, select low and enable high.
// - RAM select comes from port bit latched each strobe cycle.
// - RAM write only with calibration switch on and write strobe low.
// - RAM uses eight latched address bits and four low data lines.
// - on power loss RAM enable drops, blocking writes to battery RAM.
// - program memory enabled while program store enable low; address from latch, ports.
// - address latch captures low address byte when strobe goes low.
module rwg_top #(
  parameter int PWRUP_CYC = rwg_pkg::PWRUP_CYC,
  parameter int CHARGE_CYC = rwg_pkg::CHARGE_CYC,
  parameter int WD_TAP = rwg_pkg::WD_TAP
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // supervisor pins
  input wire logic supply_ok,
  input wire logic ale,
  input wire logic keyboard_scan_line,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cal_enable_sw,
  input wire logic program_store_enable,
  input wire logic ram_select_port_bit,
  input wire logic [4:0] rom_port_addr,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic [7:0] ad_oe,
  output logic ctrl_reset_n,
  output logic single_step_n,
  output logic rom_ce_n,
  output logic [12:0] rom_addr,
  output rwg_pkg::rwg_ram_ctl_t ram_ctl
);

  // ---------------- bus slave ----------------
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic wd_en_q;
  logic force_q;

  wire addr_phase = hsel && hready && (htrans == rwg_pkg::HTRANS_NONSEQ ||
                                       htrans == rwg_pkg::HTRANS_SEQ);
  wire [11:0] dec_addr = haddr[11:0];
  wire wr_ctrl = wr_pend_q && (wr_addr_q == rwg_pkg::CTRL_OFF);

  rwg_pkg::rwg_state_t state_q;
  rwg_pkg::rwg_state_t state_d;
  logic [rwg_pkg::WD_W-1:0] wd_cnt_q;
  logic [rwg_pkg::WD_W-1:0] wd_cnt_d;
  rwg_pkg::rwg_status_t status;

  wire [31:0] rd_mux;
  assign rd_mux = (dec_addr == rwg_pkg::CTRL_OFF) ? {30'h0, force_q, wd_en_q} :
                  (dec_addr == rwg_pkg::STATUS_OFF) ? {25'h0, status} :
                  (dec_addr == rwg_pkg::WDCNT_OFF) ? {12'h0, wd_cnt_q} :
                  32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q <= 32'h0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
      begin
        wr_addr_q <= dec_addr;
      end
      if (addr_phase && !hwrite)
      begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = rwg_pkg::HRESP_OKAY;

  // ---------------- strobe edge detect ----------------
  logic ale_q;
  logic scan_q;
  wire ale_fall = ale_q && !ale;
  wire scan_edge = scan_q ^ keyboard_scan_line;
  wire running = (state_q == rwg_pkg::ST_RUN);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ale_q <= 1'b1;
      scan_q <= 1'b0;
    end
    else
    begin
      ale_q <= ale;
      scan_q <= keyboard_scan_line;
    end
  end

  // ---------------- control register ----------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_en_q <= rwg_pkg::CTRL_WD_EN_RST;
      force_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        wd_en_q <= hwdata[rwg_pkg::CTRL_WD_EN_BIT];
      end
      // software reset request, cleared once reset is taken
      if (wr_ctrl && hwdata[rwg_pkg::CTRL_FORCE_BIT])
      begin
        force_q <= 1'b1;
      end
      else if (!running)
      begin
        force_q <= 1'b0;
      end
    end
  end

  // ---------------- watchdog ----------------
  always_comb
  begin
    wd_cnt_d = wd_cnt_q;
    if (!running)
    begin
      wd_cnt_d = '0;
    end
    else if (scan_edge)
    begin
      wd_cnt_d = '0;
    end
    else if (ale_fall && wd_en_q && !wd_cnt_q[WD_TAP])
    begin
      wd_cnt_d = wd_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_cnt_q <= '0;
    end
    else
    begin
      wd_cnt_q <= wd_cnt_d;
    end
  end

  // tap chosen for about 1.3 s at nominal strobe rate
  wire reset_req = wd_cnt_q[WD_TAP] || force_q;

  // ---------------- reset sequencer ----------------
  logic [rwg_pkg::DLY_W-1:0] dly_q;
  logic [rwg_pkg::DLY_W-1:0] dly_d;

  always_comb
  begin
    state_d = state_q;
    dly_d = dly_q;
    case (state_q)
      rwg_pkg::ST_OFF:
      begin
        if (supply_ok)
        begin
          state_d = rwg_pkg::ST_HOLD;
          dly_d = rwg_pkg::DLY_W'(PWRUP_CYC - 1);
        end
      end
      rwg_pkg::ST_HOLD:
      begin
        if (dly_q == '0)
        begin
          state_d = rwg_pkg::ST_RUN;
        end
        else
        begin
          dly_d = dly_q - 1'b1;
        end
      end
      rwg_pkg::ST_RUN:
      begin
        if (reset_req)
        begin
          state_d = rwg_pkg::ST_WDREQ;
        end
      end
      rwg_pkg::ST_WDREQ:
      begin
        if (!reset_req)
        begin
          state_d = rwg_pkg::ST_HOLD;
          dly_d = rwg_pkg::DLY_W'(CHARGE_CYC - 1);
        end
      end
      default:
      begin
        state_d = rwg_pkg::ST_OFF;
      end
    endcase
    if (!supply_ok)
    begin
      state_d = rwg_pkg::ST_OFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= rwg_pkg::ST_OFF;
      dly_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      dly_q <= dly_d;
    end
  end

  // supply loss cuts reset and RAM enable in the same cycle
  assign ctrl_reset_n = running && supply_ok;
  assign single_step_n = ctrl_reset_n;

  assign status.state = state_q;
  assign status.cal_sw = cal_enable_sw;
  assign status.supply_ok = supply_ok;
  assign status.ram_enable_hi = ram_ctl.enable_hi;
  assign status.reset_req = reset_req;
  assign status.ctrl_reset_n = ctrl_reset_n;

  // ---------------- address and select latch ----------------
  logic [7:0] addr_q;
  logic sel_lo_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= 8'h00;
      sel_lo_q <= 1'b1;
    end
    else if (ale_fall)
    begin
      addr_q <= ad_i;
      sel_lo_q <= ram_select_port_bit;
    end
  end

  // ---------------- program memory ----------------
  assign rom_ce_n = program_store_enable;
  assign rom_addr = {rom_port_addr, addr_q};

  // ---------------- calibration RAM ----------------
  logic [rwg_pkg::RAM_DW-1:0] cal_mem [rwg_pkg::RAM_DEPTH];
  logic [rwg_pkg::RAM_DW-1:0] rd_nib_q;

  assign ram_ctl.enable_hi = ctrl_reset_n;
  assign ram_ctl.select_lo = sel_lo_q;
  assign ram_ctl.output_disable = rd_n;
  assign ram_ctl.rw_n = !(cal_enable_sw && !wr_n);

  wire ram_sel = ram_ctl.enable_hi && !ram_ctl.select_lo;
  wire ram_wr = ram_sel && !ram_ctl.rw_n;
  wire ram_drive = ram_sel && !ram_ctl.output_disable;

  // battery backed: contents are not cleared by reset
  always_ff @(posedge hclk)
  begin
    if (ram_wr)
    begin
      cal_mem[addr_q] <= ad_i[rwg_pkg::RAM_DW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_nib_q <= 4'h0;
    end
    else
    begin
      rd_nib_q <= cal_mem[addr_q];
    end
  end

  assign ad_o = {4'h0, rd_nib_q};
  assign ad_oe = {4'h0, {rwg_pkg::RAM_DW{ram_drive}}};

  // ---------------- checks ----------------
  logic [3:0] hold_cnt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_cnt_q <= 4'h0;
    end
    else if (ctrl_reset_n)
    begin
      hold_cnt_q <= 4'h0;
    end
    else if (hold_cnt_q != 4'hF)
    begin
      hold_cnt_q <= hold_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wd_count_a: assert property (running && ale_fall && !scan_edge && wd_en_q && !reset_req
    |=> wd_cnt_q == $past(wd_cnt_q) + 1'b1)
    else $error("watchdog did not advance on strobe");
  wd_clear_a: assert property (running && scan_edge |=> wd_cnt_q == '0)
    else $error("scan edge did not clear watchdog");
  wd_timeout_a: assert property (running && supply_ok && wd_cnt_q[WD_TAP]
    |=> !ctrl_reset_n)
    else $error("watchdog timeout did not reset");
  req_drop_a: assert property (state_q == rwg_pkg::ST_WDREQ |-> ##[1:2] !reset_req)
    else $error("reset request stayed high during reset");
  charge_hold_a: assert property ((state_q == rwg_pkg::ST_WDREQ) && !reset_req
    |=> !ctrl_reset_n [*8])
    else $error("reset released before charge delay");
  por_hold_a: assert property ($rose(supply_ok) |-> !ctrl_reset_n [*8])
    else $error("reset released too early at power-up");
  supply_reset_a: assert property (!supply_ok |-> !ctrl_reset_n && !ram_ctl.enable_hi)
    else $error("reset not low on supply loss");
  step_follow_a: assert property (!ctrl_reset_n |-> !single_step_n && rom_ce_n)
    else $error("single step high during reset");
  release_hold_a: assert property ($rose(ctrl_reset_n) |-> hold_cnt_q >= 4'h8)
    else $error("reset released after too short a hold");
  ram_off_a: assert property (!ctrl_reset_n |-> !ram_ctl.enable_hi && !ram_wr)
    else $error("RAM enabled during reset");
  ram_drive_a: assert property (ad_oe != 8'h00
    |-> !rd_n && !ram_ctl.select_lo && ram_ctl.enable_hi)
    else $error("RAM drove bus without read select");
  sel_latch_a: assert property (ale_fall |=> ram_ctl.select_lo == $past(ram_select_port_bit))
    else $error("select latch missed port bit");
  ram_write_a: assert property (!ram_ctl.rw_n |-> cal_enable_sw && !wr_n)
    else $error("RAM write without cal switch");
  addr_latch_a: assert property (ale_fall |=> addr_q == $past(ad_i) && rom_addr[7:0] == $past(ad_i))
    else $error("address latch missed low byte");

  wd_reset_c: cover property (running && reset_req ##1 !ctrl_reset_n);
  por_done_c: cover property (state_q == rwg_pkg::ST_HOLD ##1 ctrl_reset_n);
  ram_write_c: cover property (ram_wr);
  ram_read_c: cover property (ram_drive);

endmodule : rwg_top

// ### tb/rwg_ctrl_model.sv
`timescale 1ns/1ps
module rwg_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ctrl_reset_n,
  input wire logic ale_run,
  input wire logic scan_run,
  output logic ale,
  output logic keyboard_scan_line,
  output logic program_store_enable
);
  logic [3:0] div_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 4'h0;
      ale <= 1'b1;
      keyboard_scan_line <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 4'h1;
      // strobe halts while the controller is held in reset
      if (ale_run && ctrl_reset_n && div_q[0]) ale <= ~ale;
      if (scan_run && div_q == 4'hF) keyboard_scan_line <= ~keyboard_scan_line;
    end
  end
  // fetch strobe is parked high while the controller is held in reset
  assign program_store_enable = ctrl_reset_n ? ~ale : 1'b1;
endmodule : rwg_ctrl_model

// ### tb/test_rwg_top.sv
`timescale 1ns/1ps
module test_rwg_top;
  localparam int PW = 20;
  localparam int CH = 20;
  logic hclk, hresetn, hsel, hwrite, hready, supply_ok, ale, kbd, rd_n, wr_n, sw, pse, sel_bit;
  logic ale_run, scan_run, hreadyout, hresp, ctrl_reset_n, single_step_n, rom_ce_n;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] rom_port_addr;
  logic [7:0] ad_i, ad_o, ad_oe;
  logic [12:0] rom_addr;
  rwg_pkg::rwg_ram_ctl_t ram_ctl;
  int num_errors, check_count, n;
  assign hready = hreadyout;
  rwg_top #(.PWRUP_CYC(PW), .CHARGE_CYC(CH), .WD_TAP(3)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .supply_ok(supply_ok), .ale(ale), .keyboard_scan_line(kbd), .rd_n(rd_n), .wr_n(wr_n),
    .cal_enable_sw(sw), .program_store_enable(pse), .ram_select_port_bit(sel_bit),
    .rom_port_addr(rom_port_addr), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe),
    .ctrl_reset_n(ctrl_reset_n), .single_step_n(single_step_n), .rom_ce_n(rom_ce_n),
    .rom_addr(rom_addr), .ram_ctl(ram_ctl));
  rwg_ctrl_model ctrl (.hclk(hclk), .hresetn(hresetn), .ctrl_reset_n(ctrl_reset_n),
    .ale_run(ale_run), .scan_run(scan_run), .ale(ale), .keyboard_scan_line(kbd),
    .program_store_enable(pse));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h got %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= rwg_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : ahb
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (ctrl_reset_n !== lvl && n < 1000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_rst
  task automatic test_power_up;
    chk("reset_low", 0, ctrl_reset_n);
    chk("step_low", 0, single_step_n);
    chk("ram_en_low", 0, ram_ctl.enable_hi);
    chk("rom_off", 1, rom_ce_n);
    wait_rst(1'b1);
    chk("pwrup_held", 1, n >= PW && n < PW + 4);
    chk("ram_en_high", 1, ram_ctl.enable_hi);
    $display("power-up test done");
  endtask : test_power_up
  task automatic test_regs;
    ahb(1'b0, 32'h0000_0000, 32'h0);
    chk("ctrl_rst", 32'h0000_0001, d);
    chk("hresp", rwg_pkg::HRESP_OKAY, hresp);
    chk("hreadyout", 1, hreadyout);
    ahb(1'b0, 32'h0000_0004, 32'h0);
    chk("status", 32'h0000_0009, d & 32'h0000_0009);
    ahb(1'b0, 32'h0000_000C, 32'h0);
    chk("unmapped", 32'h0, d);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0003);
    wait_rst(1'b0);
    chk("force_rst", 1, n < 6);
    wait_rst(1'b1);
    $display("register test done");
  endtask : test_regs
  task automatic test_watchdog;
    ale_run <= 1'b1;
    n = 0;
    repeat (300)
    begin
      @(posedge hclk);
      if (ctrl_reset_n !== 1'b1) n++;
    end
    chk("scan_keeps_run", 0, n);
    ahb(1'b0, 32'h0000_0008, 32'h0);
    chk("count_low", 0, d >> 3);
    ahb(1'b1, 32'h0000_0000, 32'h0);
    scan_run <= 1'b0;
    n = 0;
    repeat (60)
    begin
      @(posedge hclk);
      if (ctrl_reset_n !== 1'b1) n++;
    end
    chk("wd_disabled", 0, n);
    scan_run <= 1'b1;
    @(kbd);
    ahb(1'b1, 32'h0000_0000, 32'h1);
    @(kbd);
    @(posedge hclk);
    scan_run <= 1'b0;
    wait_rst(1'b0);
    chk("wd_fires", 1, n >= 28 && n < 60);
    scan_run <= 1'b1;
    wait_rst(1'b1);
    chk("charge_hold", 1, n >= CH && n < CH + 4);
    ale_run <= 1'b0;
    $display("watchdog test done");
  endtask : test_watchdog
  task automatic test_supply;
    @(posedge hclk);
    supply_ok <= 1'b0;
    #1;
    chk("loss_reset", 0, ctrl_reset_n);
    chk("loss_ram_en", 0, ram_ctl.enable_hi);
    @(posedge hclk);
    supply_ok <= 1'b1;
    wait_rst(1'b1);
    chk("restart", 1, n >= PW && n < PW + 4);
    $display("supply test done");
  endtask : test_supply
  task automatic ram_op(input logic [7:0] a, input logic [3:0] wd, input logic on,
    input logic [3:0] e);
    sel_bit <= 1'b0;
    ad_i <= a;
    ale_run <= 1'b1;
    repeat (12) @(posedge hclk);
    ale_run <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("latched_addr", {rom_port_addr, a}, rom_addr);
    chk("rom_ce", pse, rom_ce_n);
    chk("select", 0, ram_ctl.select_lo);
    ad_i <= {4'h0, wd};
    sw <= on;
    wr_n <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rw_n", !on, ram_ctl.rw_n);
    wr_n <= 1'b1;
    @(posedge hclk);
    rd_n <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk("oe", 8'h0F, ad_oe);
    chk("nibble", e, ad_o[3:0]);
    @(posedge hclk);
    rd_n <= 1'b1;
    sw <= 1'b0;
  endtask : ram_op
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    #300000;
    num_errors++;
    $display("ERROR watchdog expected finish got timeout");
    complete_run();
  end
  initial
  begin
    {hresetn, hsel, hwrite, sw, sel_bit, ale_run} = 6'h0;
    {supply_ok, rd_n, wr_n, scan_run} = 4'hF;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    rom_port_addr = 5'h15;
    ad_i = 8'h00;
    num_errors = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_power_up();
    test_regs();
    test_watchdog();
    ram_op(8'h3C, 4'hA, 1'b1, 4'hA);
    ram_op(8'h3C, 4'h5, 1'b0, 4'hA);
    ram_op(8'hC3, 4'h5, 1'b1, 4'h5);
    $display("ram test done");
    test_supply();
    complete_run();
  end
endmodule : test_rwg_top
